// >>> duc_pkg.sv
// duc_pkg: constants and types shared by the output update control block.
// assumes a single 250 MHz system clock and an active-low async reset.
package duc_pkg;

  // ==========================================================================
  // sizes
  localparam int unsigned NUM_CH    = 8;
  localparam int unsigned NUM_GPIO  = 3;
  localparam int unsigned NUM_GRP   = 2;
  localparam int unsigned CODE_W    = 12;
  localparam int unsigned CH_IDX_W  = 3;
  localparam int unsigned MON_SEL_W = 4;

  // ==========================================================================
  // reset values
  localparam logic [CODE_W-1:0] CODE_LOW       = 12'h000;
  localparam logic [CODE_W-1:0] CODE_MID       = 12'h800;
  localparam logic [CODE_W-1:0] OFS_DEF_BIN    = 12'h99a;
  localparam logic [CODE_W-1:0] OFS_DEF_TWOS   = 12'h19a;
  localparam logic [CODE_W-1:0] GAIN_DEF       = 12'h800;
  localparam logic [CODE_W-1:0] ZERO_DEF       = 12'h000;
  localparam logic [CODE_W-1:0] INPUT_DEF      = 12'h000;
  localparam logic [NUM_GPIO-1:0] GPIO_DEF     = 3'h7;

  // ==========================================================================
  // monitor source codes
  localparam logic [MON_SEL_W-1:0] MON_AUX0    = 4'h8;
  localparam logic [MON_SEL_W-1:0] MON_AUX1    = 4'h9;
  localparam logic [MON_SEL_W-1:0] MON_OFS_A   = 4'ha;
  localparam logic [MON_SEL_W-1:0] MON_OFS_B   = 4'hb;
  localparam logic [MON_SEL_W-1:0] MON_REF_A   = 4'hc;
  localparam logic [MON_SEL_W-1:0] MON_REF_B   = 4'hd;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned RECOVER_US       = 200;
  localparam int unsigned RECOVER_CYC      = RECOVER_US * CLK_MHZ;
  localparam int unsigned REC_CNT_W        = 16;
  // pin synchroniser settle time before the update mode is captured
  localparam int unsigned BOOT_SETTLE      = 4;

  // ==========================================================================
  // update mode
  typedef enum logic [1:0] {
    DUC_MODE_ASYNC = 2'b01,
    DUC_MODE_SYNC  = 2'b10
  } duc_mode_t;

endpackage

// >>> duc_sync3.sv
// duc_sync3: three-flop pin synchroniser with agreement filter.
// assumes the input is asynchronous to clk_sys; output changes when stages 2 and 3 agree.
module duc_sync3 import duc_pkg::*; #(
  parameter int unsigned W        = 1,
  parameter logic [W-1:0] INIT    = '0
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  // data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } duc_sync_t;

  duc_sync_t st;
  duc_sync_t next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < int'(W); i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.q[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st <= '{s1: INIT, s2: INIT, s3: INIT, q: INIT};
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.q;

endmodule

// >>> duc_ctrl.sv
// duc_ctrl: decides when channel latches and outputs change.
// assumes a serial front end (not here) decodes writes into one-cycle strobes
// on clk_sys; analog switches are steered by the flop outputs below.
module duc_ctrl import duc_pkg::*; #(
  parameter int unsigned RECOVER_CYCLES = RECOVER_CYC
) (
  // clock and reset (nrst is power-on reset)
  input  wire logic                        clk_sys,
  input  wire logic                        nrst,
  // pins
  input  wire logic                        hw_reset_n,
  input  wire logic                        output_clear_n,
  input  wire logic                        latch_load_n,
  input  wire logic                        reset_value_select,
  input  wire logic                        code_format_select,
  input  wire logic [NUM_GPIO-1:0]         gpio_in,
  output logic      [NUM_GPIO-1:0]         gpio_out,
  output logic      [NUM_GPIO-1:0]         gpio_oe_n,
  // register writes from the serial front end
  input  wire logic                        soft_reset,
  input  wire logic                        cs_rise,
  input  wire logic                        data_wr,
  input  wire logic [CH_IDX_W-1:0]         data_ch,
  input  wire logic [CODE_W-1:0]           data_val,
  input  wire logic                        gpio_wr,
  input  wire logic [NUM_GPIO-1:0]         gpio_wdata,
  input  wire logic                        soft_latch_load,
  input  wire logic                        correction_engine_on,
  input  wire logic                        corr_done,
  input  wire logic [CH_IDX_W-1:0]         corr_ch,
  input  wire logic [CODE_W-1:0]           corr_val,
  input  wire logic                        monitor_en,
  input  wire logic [MON_SEL_W-1:0]        monitor_sel,
  input  wire logic [NUM_GRP-1:0]          group_power_down,
  // status and analog control
  output logic      [NUM_GPIO-1:0]         gpio_rdata,
  output logic                             serial_enable,
  output logic                             sync_mode,
  output logic      [NUM_CH*CODE_W-1:0]    latch_code,
  output logic      [NUM_CH*CODE_W-1:0]    data_code,
  output logic      [CODE_W-1:0]           input_code,
  output logic      [CODE_W-1:0]           gain_code,
  output logic      [CODE_W-1:0]           zero_code,
  output logic      [NUM_GRP*CODE_W-1:0]   offset_code,
  output logic      [NUM_CH-1:0]           channel_output_gnd,
  output logic      [NUM_CH-1:0]           channel_output_hiz,
  output logic      [NUM_GRP-1:0]          group_ready,
  output logic                             monitor_out_en,
  output logic      [MON_SEL_W-1:0]        monitor_out_sel
);

  // ==========================================================================
  // pin synchronisers
  logic hrst_n_s;
  logic clr_n_s;
  logic ld_n_s;
  logic rsel_s;
  logic fmt_s;
  logic [NUM_GPIO-1:0] gpio_s;

  duc_sync3 #(.W(5), .INIT(5'h1f)) u_sync_pins (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .din     ({hw_reset_n, output_clear_n, latch_load_n,
                reset_value_select, code_format_select}),
    .dout    ({hrst_n_s, clr_n_s, ld_n_s, rsel_s, fmt_s})
  );

  duc_sync3 #(.W(NUM_GPIO), .INIT(GPIO_DEF)) u_sync_gpio (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .din     (gpio_in),
    .dout    (gpio_s)
  );

  // ==========================================================================
  // state
  typedef struct packed {
    logic                       booted;
    logic [2:0]                 boot_cnt;
    duc_mode_t                  mode;
    logic                       ld_prev;
    logic                       clr_hold;
    logic [NUM_CH-1:0]          touched;
    logic [NUM_CH*CODE_W-1:0]   data;
    logic [NUM_CH*CODE_W-1:0]   latch;
    logic [CODE_W-1:0]          inp;
    logic [CODE_W-1:0]          gain;
    logic [CODE_W-1:0]          zero;
    logic [NUM_GRP*CODE_W-1:0]  ofs;
    logic [NUM_GPIO-1:0]        gpio;
    logic [NUM_GPIO-1:0]        gpio_rd;
    logic                       ser_en;
    logic [NUM_CH-1:0]          gnd;
    logic [NUM_CH-1:0]          hiz;
    logic [NUM_GRP-1:0]         pd_prev;
    logic [NUM_GRP-1:0]         rdy;
    logic [NUM_GRP*REC_CNT_W-1:0] rec_cnt;
    logic                       mon_en;
    logic [MON_SEL_W-1:0]       mon_sel;
  } duc_state_t;

  duc_state_t st;
  duc_state_t next_st;

  // reset code per rsel/format: 800h when they differ
  function automatic logic [CODE_W-1:0] reset_code(input logic rsel, input logic fmt);
    reset_code = (rsel ^ fmt) ? CODE_MID : CODE_LOW;
  endfunction

  function automatic logic [CODE_W-1:0] ofs_default(input logic fmt);
    ofs_default = fmt ? OFS_DEF_TWOS : OFS_DEF_BIN;
  endfunction

  localparam logic [REC_CNT_W-1:0] REC_LOAD = REC_CNT_W'(RECOVER_CYCLES - 1);

  logic ld_fall;
  logic load_event;
  logic in_reset;
  logic clr_active;

  always_comb begin
    next_st    = st;
    in_reset   = !hrst_n_s || soft_reset;
    clr_active = !clr_n_s || st.clr_hold;
    ld_fall    = st.ld_prev && !ld_n_s;
    // clear masks load pulses; tied-low load restores at release
    load_event = (st.mode == DUC_MODE_SYNC) && clr_n_s
                 && (ld_fall || soft_latch_load);
    next_st.ld_prev = ld_n_s;

    // mode captured once, after the pin synchronisers have settled;
    // sampling any earlier would only see their reset level
    if (!st.booted && (st.boot_cnt != 3'(BOOT_SETTLE))) begin
      next_st.boot_cnt = st.boot_cnt + 3'h1;
    end else if (!st.booted) begin
      next_st.booted = 1'b1;
      next_st.mode   = ld_n_s ? DUC_MODE_SYNC : DUC_MODE_ASYNC;
      for (int c = 0; c < int'(NUM_CH); c++) begin
        next_st.data[c*CODE_W +: CODE_W]  = reset_code(rsel_s, fmt_s);
        next_st.latch[c*CODE_W +: CODE_W] = reset_code(rsel_s, fmt_s);
      end
      for (int g = 0; g < int'(NUM_GRP); g++) begin
        next_st.ofs[g*CODE_W +: CODE_W] = ofs_default(fmt_s);
      end
    end else if (in_reset) begin
      // hold reset values and block serial traffic
      next_st.ser_en  = 1'b0;
      next_st.touched = '0;
      next_st.inp     = INPUT_DEF;
      next_st.gain    = GAIN_DEF;
      next_st.zero    = ZERO_DEF;
      next_st.gpio    = GPIO_DEF;
      for (int c = 0; c < int'(NUM_CH); c++) begin
        next_st.data[c*CODE_W +: CODE_W]  = reset_code(rsel_s, fmt_s);
        next_st.latch[c*CODE_W +: CODE_W] = reset_code(rsel_s, fmt_s);
      end
      for (int g = 0; g < int'(NUM_GRP); g++) begin
        next_st.ofs[g*CODE_W +: CODE_W] = ofs_default(fmt_s);
      end
    end else begin
      // values held until reprogrammed; serial back on
      next_st.ser_en = 1'b1;
      // serial stays live regardless of power-down state
      if (gpio_wr) begin
        next_st.gpio = gpio_wdata;
      end
      if (st.mode == DUC_MODE_ASYNC) begin
        // load pin and soft load have no effect here
        if (!correction_engine_on && data_wr) begin
          next_st.data[data_ch*CODE_W +: CODE_W]  = data_val;
          next_st.latch[data_ch*CODE_W +: CODE_W] = data_val;
        end else if (correction_engine_on && data_wr) begin
          next_st.inp = data_val;
        end
        if (correction_engine_on && corr_done) begin
          next_st.data[corr_ch*CODE_W +: CODE_W]  = corr_val;
          next_st.latch[corr_ch*CODE_W +: CODE_W] = corr_val;
        end
      end else begin
        if (load_event) begin
          for (int c = 0; c < int'(NUM_CH); c++) begin
            if (st.touched[c]) begin
              next_st.latch[c*CODE_W +: CODE_W] = st.data[c*CODE_W +: CODE_W];
            end
          end
          next_st.touched = '0;
        end
        // a write in the load cycle stays pending for the next load
        if (!correction_engine_on && data_wr) begin
          next_st.data[data_ch*CODE_W +: CODE_W] = data_val;
          next_st.touched[data_ch] = 1'b1;
        end else if (correction_engine_on && data_wr) begin
          next_st.inp = data_val;
        end
        // with correction on, the channel counts as accessed once corrected
        if (correction_engine_on && corr_done) begin
          next_st.data[corr_ch*CODE_W +: CODE_W] = corr_val;
          next_st.touched[corr_ch] = 1'b1;
        end
      end
    end

    // clear release with load high keeps outputs cleared until load low
    if (!clr_n_s) begin
      next_st.clr_hold = ld_n_s;
    end else if (!ld_n_s) begin
      next_st.clr_hold = 1'b0;
    end

    // gpio: one floats (oe_n high), zero pulls low
    next_st.gpio_rd = gpio_s;

    // group power-down and recovery timers
    for (int g = 0; g < int'(NUM_GRP); g++) begin
      next_st.pd_prev[g] = group_power_down[g];
      if (group_power_down[g]) begin
        next_st.rdy[g] = 1'b0;
        next_st.rec_cnt[g*REC_CNT_W +: REC_CNT_W] = REC_LOAD;
      end else if (!st.rdy[g]) begin
        if (st.rec_cnt[g*REC_CNT_W +: REC_CNT_W] == '0) begin
          next_st.rdy[g] = 1'b1;
        end else begin
          next_st.rec_cnt[g*REC_CNT_W +: REC_CNT_W] =
            st.rec_cnt[g*REC_CNT_W +: REC_CNT_W] - 1'b1;
        end
      end
    end

    // output switches: clear wins over everything, registers untouched
    for (int c = 0; c < int'(NUM_CH); c++) begin
      next_st.gnd[c] = clr_active || group_power_down[c / 4];
      next_st.hiz[c] = clr_active || group_power_down[c / 4];
    end

    // monitor mux follows its register; disabled means float
    next_st.mon_en  = monitor_en;
    next_st.mon_sel = monitor_sel;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st         <= '0;
      st.mode    <= DUC_MODE_ASYNC;
      st.ld_prev <= 1'b1;
      st.gain    <= GAIN_DEF;
      st.zero    <= ZERO_DEF;
      st.inp     <= INPUT_DEF;
      st.gpio    <= GPIO_DEF;
      st.gnd     <= '1;
      st.hiz     <= '1;
      st.rdy     <= '1;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // outputs straight from state flops, except gpio_out which is tied low
  assign gpio_out           = '0;
  assign gpio_oe_n          = st.gpio;
  assign gpio_rdata         = st.gpio_rd;
  assign serial_enable      = st.ser_en;
  // one-hot mode: bit 1 is the sync code, so this is a plain flop
  assign sync_mode          = st.mode[1];
  assign latch_code         = st.latch;
  assign data_code          = st.data;
  assign input_code         = st.inp;
  assign gain_code          = st.gain;
  assign zero_code          = st.zero;
  assign offset_code        = st.ofs;
  assign channel_output_gnd = st.gnd;
  assign channel_output_hiz = st.hiz;
  assign group_ready        = st.rdy;
  assign monitor_out_en     = st.mon_en;
  assign monitor_out_sel    = st.mon_sel;

endmodule

// >>> duc_ctrl_asserts.sv
// duc_ctrl_asserts: port-level checks for duc_ctrl.
// assumes it is bound to duc_ctrl and sees only its ports.
module duc_ctrl_asserts import duc_pkg::*; #(
  parameter int unsigned RECOVER_CYCLES = 20
) (
  // clock and reset
  input wire logic                   clk_sys,
  input wire logic                   nrst,
  // inputs watched
  input wire logic                   output_clear_n,
  input wire logic                   soft_reset,
  input wire logic                   data_wr,
  input wire logic [CH_IDX_W-1:0]    data_ch,
  input wire logic [CODE_W-1:0]      data_val,
  input wire logic                   gpio_wr,
  input wire logic [NUM_GPIO-1:0]    gpio_wdata,
  input wire logic                   correction_engine_on,
  input wire logic                   monitor_en,
  input wire logic [MON_SEL_W-1:0]   monitor_sel,
  input wire logic [NUM_GRP-1:0]     group_power_down,
  // outputs watched
  input wire logic [NUM_GPIO-1:0]    gpio_out,
  input wire logic [NUM_GPIO-1:0]    gpio_oe_n,
  input wire logic                   serial_enable,
  input wire logic                   sync_mode,
  input wire logic [NUM_CH*CODE_W-1:0] latch_code,
  input wire logic [NUM_CH-1:0]      channel_output_gnd,
  input wire logic [NUM_CH-1:0]      channel_output_hiz,
  input wire logic [NUM_GRP-1:0]     group_ready,
  input wire logic                   monitor_out_en,
  input wire logic [MON_SEL_W-1:0]   monitor_out_sel
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RLO = RECOVER_CYCLES - 1;
  localparam int RHI = RECOVER_CYCLES + 1;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ====================
  // gpio
  a_gpio_low: assert property (gpio_out == '0)
    else $error("gpio drives high");
  a_gpio_write: assert property (gpio_wr && serial_enable && !soft_reset
    |=> gpio_oe_n == $past(gpio_wdata)) else $error("gpio bit not applied");
  a_gpio_reset: assert property (!serial_enable || $past(soft_reset)
    |-> gpio_oe_n == GPIO_DEF) else $error("gpio not reset to one");
  // ====================
  // clear and latches
  a_clear_force: assert property ($fell(output_clear_n)
    |-> ##[3:6] (&channel_output_gnd && &channel_output_hiz)) else $error("clear late");
  // load pulses during a settled clear must not move any latch
  a_clear_hold: assert property (sync_mode && serial_enable && $past(serial_enable)
    && !soft_reset && !output_clear_n && !$past(output_clear_n, 5)
    |-> $stable(latch_code)) else $error("latch moved under clear");
  a_async_write: assert property (!sync_mode && !correction_engine_on && data_wr
    && serial_enable && !soft_reset |=> latch_code[$past(data_ch)*CODE_W +: CODE_W]
    == $past(data_val)) else $error("async latch not written");
  // ====================
  // monitor and power-down
  a_mon_route: assert property ($stable(monitor_en) && $stable(monitor_sel)
    && serial_enable |=> monitor_out_en == $past(monitor_en)
    && (!monitor_out_en || monitor_out_sel == $past(monitor_sel))) else $error("monitor");
  a_pd_float: assert property (group_power_down[0] && $past(group_power_down[0])
    |-> &channel_output_hiz[3:0] && &channel_output_gnd[3:0]) else $error("pd not hiz");
  a_pd_recover: assert property ($fell(group_power_down[0])
    |-> !group_ready[0] [*2] ##[RLO:RHI] group_ready[0]) else $error("recovery late");
endmodule

bind duc_ctrl duc_ctrl_asserts #(.RECOVER_CYCLES(RECOVER_CYCLES)) duc_ctrl_asserts_inst (.*);

// >>> duc_host.sv
// duc_host: board and host side of the gpio pins.
// assumes pull-ups on every gpio line; ext_low stands for a board driver.
module duc_host import duc_pkg::*; (
  // pin drive
  input  wire logic [NUM_GPIO-1:0] gpio_oe_n,
  input  wire logic [NUM_GPIO-1:0] gpio_out,
  input  wire logic [NUM_GPIO-1:0] ext_low,
  // resolved level and host strobe
  output logic      [NUM_GPIO-1:0] gpio_in,
  output logic                     cs_rise
);
  timeunit 1ns;
  timeprecision 100ps;
  // wired line with pull-up: any party pulling low wins
  assign gpio_in = ~((~gpio_oe_n & ~gpio_out) | ext_low);
  // chip select stays high, no frame ever closes here
  assign cs_rise = 1'b0;
endmodule

// >>> testbench.sv
// testbench: self-checking bench for duc_ctrl.
// assumes duc_host resolves the gpio pins; recovery count cut to 20.
module testbench import duc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [2:0] ch; logic [11:0] v; logic [2:0] gw, ext, rd;} duc_row_t;
  localparam int RC = 20;
  localparam duc_row_t ROWS [4] = '{'{3'h0, 12'h0fff, 3'h7, 3'h0, 3'h7},
    '{3'h7, 12'h0001, 3'h5, 3'h0, 3'h5}, '{3'h3, 12'h0000, 3'h7, 3'h2, 3'h5},
    '{3'h4, 12'h05a5, 3'h0, 3'h0, 3'h0}};
  logic clk_sys = 1'b0;
  logic nrst, hw_reset_n, output_clear_n, latch_load_n, reset_value_select, cs_rise;
  logic code_format_select, soft_reset, data_wr, gpio_wr, soft_latch_load;
  logic correction_engine_on, corr_done, monitor_en, serial_enable, sync_mode, monitor_out_en;
  logic [2:0] data_ch, corr_ch, gpio_wdata, ext_low, gpio_in, gpio_out, gpio_oe_n, gpio_rdata;
  logic [11:0] data_val, corr_val, input_code, gain_code, zero_code;
  logic [3:0] monitor_sel, monitor_out_sel;
  logic [1:0] group_power_down, group_ready;
  logic [95:0] latch_code, data_code;
  logic [23:0] offset_code;
  logic [7:0] channel_output_gnd, channel_output_hiz;
  int failures = 0;
  int checks_done = 0;
  int n;
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
  $display("Error at %0t: got %h want %h", $time, a, b); end end
  duc_ctrl #(.RECOVER_CYCLES(RC)) duc_ctrl_inst (.*);
  duc_host duc_host_inst (.*);
  always #2 clk_sys = ~clk_sys;
  function automatic logic [11:0] lc(input int c);
    return latch_code[c*12 +: 12];
  endfunction
  function automatic logic [11:0] dc(input int c);
    return data_code[c*12 +: 12];
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [2:0] c, input logic [11:0] v);
    @(posedge clk_sys);
    data_wr <= 1'b1;
    data_ch <= c;
    data_val <= v;
    @(posedge clk_sys);
    data_wr <= 1'b0;
  endtask
  task automatic soft_load();
    @(posedge clk_sys);
    soft_latch_load <= 1'b1;
    @(posedge clk_sys);
    soft_latch_load <= 1'b0;
    tick(2);
  endtask
  // pins held steady across release so the mode capture sees them
  task automatic por(input logic ld, rs, fmt);
    nrst <= 1'b0;
    latch_load_n <= ld;
    reset_value_select <= rs;
    code_format_select <= fmt;
    tick(12);
    nrst <= 1'b1;
    // mode capture waits for the pin synchronisers to settle
    tick(8);
  endtask
  task automatic chk_rst(input logic [11:0] code);
    for (int c = 0; c < 8; c++) begin
      `CHK({lc(c), dc(c)}, {code, code})
    end
    `CHK(input_code, INPUT_DEF)
    `CHK({gain_code, zero_code}, {GAIN_DEF, ZERO_DEF})
    `CHK(gpio_oe_n, GPIO_DEF)
  endtask
  task automatic close_out();
    if (failures == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    {hw_reset_n, output_clear_n} <= 2'b11;
    {soft_reset, data_wr, gpio_wr, soft_latch_load, correction_engine_on} <= '0;
    {corr_done, monitor_en, data_ch, corr_ch, gpio_wdata, ext_low} <= '0;
    {data_val, corr_val, monitor_sel, group_power_down} <= '0;
    por(1'b0, 1'b1, 1'b0);
    chk_rst(CODE_MID);
    `CHK({sync_mode, offset_code}, {1'b0, OFS_DEF_BIN, OFS_DEF_BIN})
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      {data_wr, gpio_wr} <= 2'b11;
      data_ch <= ROWS[i].ch;
      data_val <= ROWS[i].v;
      gpio_wdata <= ROWS[i].gw;
      ext_low <= ROWS[i].ext;
      @(posedge clk_sys);
      {data_wr, gpio_wr} <= 2'b00;
      tick(6);
      `CHK(lc(ROWS[i].ch), ROWS[i].v)
      `CHK(gpio_oe_n, ROWS[i].gw)
      `CHK(gpio_rdata, ROWS[i].rd)
    end
    output_clear_n <= 1'b0;
    tick(8);
    `CHK({channel_output_gnd, channel_output_hiz}, 16'hffff)
    `CHK(lc(4), 12'h05a5)
    output_clear_n <= 1'b1;
    tick(8);
    `CHK(channel_output_hiz, 8'h00)
    soft_reset <= 1'b1;
    tick(1);
    soft_reset <= 1'b0;
    tick(2);
    `CHK(gpio_oe_n, GPIO_DEF)
    reset_value_select <= 1'b0;
    hw_reset_n <= 1'b0;
    tick(8);
    wr(1, 12'h0abc);
    tick(2);
    chk_rst(CODE_LOW);
    `CHK(serial_enable, 1'b0)
    hw_reset_n <= 1'b1;
    tick(6);
    `CHK({serial_enable, lc(0)}, {1'b1, CODE_LOW})
    group_power_down <= 2'b01;
    tick(3);
    `CHK({channel_output_gnd[3:0], channel_output_hiz}, 12'hf0f)
    wr(5, 12'h0321);
    tick(1);
    `CHK(lc(5), 12'h0321)
    group_power_down <= 2'b00;
    n = 0;
    while (group_ready[0] !== 1'b1 && n < RC + 5) begin
      tick(1);
      n++;
    end
    `CHK(n <= RC + 2, 1'b1)
    if (n >= RC + 5) close_out();
    for (int s = 0; s < 14; s++) begin
      monitor_en <= 1'b1;
      monitor_sel <= s[3:0];
      tick(3);
      `CHK({monitor_out_en, monitor_out_sel}, {1'b1, s[3:0]})
    end
    monitor_en <= 1'b0;
    tick(3);
    `CHK(monitor_out_en, 1'b0)
    por(1'b1, 1'b0, 1'b1);
    chk_rst(CODE_MID);
    `CHK({sync_mode, offset_code}, {1'b1, OFS_DEF_TWOS, OFS_DEF_TWOS})
    wr(2, 12'h0123);
    wr(5, 12'h0456);
    tick(2);
    `CHK({dc(2), lc(2)}, {12'h0123, CODE_MID})
    soft_load();
    `CHK({lc(2), lc(5), lc(0)}, {12'h0123, 12'h0456, CODE_MID})
    wr(3, 12'h0789);
    output_clear_n <= 1'b0;
    tick(6);
    latch_load_n <= 1'b0;
    tick(6);
    latch_load_n <= 1'b1;
    tick(6);
    `CHK(lc(3), CODE_MID)
    output_clear_n <= 1'b1;
    tick(8);
    `CHK(channel_output_hiz, 8'hff)
    latch_load_n <= 1'b0;
    tick(8);
    `CHK({channel_output_hiz, lc(3)}, {8'h00, 12'h0789})
    latch_load_n <= 1'b1;
    correction_engine_on <= 1'b1;
    wr(1, 12'h0777);
    tick(1);
    `CHK(input_code, 12'h0777)
    {corr_done, corr_ch, corr_val} <= {1'b1, 3'h1, 12'h0778};
    tick(1);
    corr_done <= 1'b0;
    soft_load();
    `CHK(lc(1), 12'h0778)
    close_out();
  end
endmodule
